// [verilog/hrs_consts.svh]
// hrs_consts.svh - offsets, field positions, reset values and widths of the return stack
// assumes: included by the return stack package and module on a single core clock
`ifndef HRS_CONSTS_SVH
`define HRS_CONSTS_SVH

// ----------------------------------------------------------------------------
// geometry
// ----------------------------------------------------------------------------
`define HRS_DEPTH 16
`define HRS_PC_W 15
`define HRS_PTR_W 5
`define HRS_IDX_W 4

// ----------------------------------------------------------------------------
// pointer values
// ----------------------------------------------------------------------------
`define HRS_PTR_EMPTY 5'h1F
`define HRS_PTR_TOP 5'h0F
`define HRS_IDX_TOP 4'hF

// ----------------------------------------------------------------------------
// register offsets on the plain port
// ----------------------------------------------------------------------------
`define HRS_ADDR_PTR 4'h0
`define HRS_ADDR_TOS_LOW 4'h1
`define HRS_ADDR_TOS_HIGH 4'h2
`define HRS_ADDR_STATUS 4'h3
`define HRS_ADDR_CLEAR 4'h4
`define HRS_ADDR_ENABLE 4'h5

// ----------------------------------------------------------------------------
// status, clear and enable fields
// ----------------------------------------------------------------------------
`define HRS_BIT_OVF 0
`define HRS_BIT_UNF 1
`define HRS_EVT_W 2
`define HRS_EVT_RESET 2'h0

`endif

// [verilog/hrs_pkg.sv]
// hrs_pkg.sv - types shared by the return stack
// assumes: hrs_consts.svh is on the include path
`include "hrs_consts.svh"

package hrs_pkg;

    // what the stack does in one core cycle
    typedef enum logic [1:0] {
        hrs_op_idle,
        hrs_op_push,
        hrs_op_pop
    } hrs_op_t;

    typedef logic [`HRS_PC_W-1:0] hrs_pc_t;
    typedef logic [`HRS_PTR_W-1:0] hrs_ptr_t;

endpackage : hrs_pkg

// [verilog/hrs_stack.sv]
// hrs_stack.sv - hardware return-address stack with pointer and top-of-stack access
// assumes: push, pop and push_pc come from the instruction sequencer on clk;
// stack_fault_reset_enable is a configuration level already on clk;
// the reset controller acts on stack_fault_reset
//
// How it works
// R1 - sixteen fifteen-bit entries, apart from program and data memory
// R2 - call, call via working reg and interrupt vectoring push the pc
// R3 - return, return with literal and return from interrupt pop the stack
// R4 - push and pop never touch the pc latch high register
// R5 - with fault reset off, pushes wrap and overwrite the oldest entries
// R6 - overflow and underflow flags set whether or not fault reset is on
// R7 - software writes the pointer, then reads or writes the top-of-stack pair
// R8 - pointer is five bits so overflow and underflow show
// R9 - push increments then stores; return loads then decrements
// R10 - pointer addresses the entry in use; top pair shows latest push
// R11 - after reset stack is empty with pointer at 0x1F
// R12 - empty stack with fault reset on reads top pair as zero
// R13 - empty stack with fault reset off reads highest entry
// R14 - with fault reset on, overflow or underflow also requests device reset
`timescale 1ns/1ps
`include "hrs_consts.svh"

module hrs_stack
    import hrs_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic push,
    input wire logic pop,
    input wire logic [`HRS_PC_W-1:0] push_pc,
    output logic [`HRS_PC_W-1:0] ret_pc,
    input wire logic stack_fault_reset_enable,
    output logic stack_fault_reset,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [7:0] reg_rdata,
    output logic irq
);

    // ------------------------------------------------------------------------
    // storage and state
    // ------------------------------------------------------------------------
    hrs_pc_t entries [`HRS_DEPTH];
    hrs_ptr_t stack_pointer;
    hrs_ptr_t next_stack_pointer;
    logic [`HRS_EVT_W-1:0] status;
    logic [`HRS_EVT_W-1:0] next_status;
    logic [`HRS_EVT_W-1:0] enable;
    logic [`HRS_EVT_W-1:0] next_enable;
    hrs_pc_t next_ret_pc;
    logic next_stack_fault_reset;
    logic [7:0] next_reg_rdata;

    hrs_op_t op;
    logic overflow;
    logic underflow;
    logic mem_we;
    logic [`HRS_IDX_W-1:0] mem_idx;
    hrs_pc_t mem_wdata;
    hrs_pc_t tos_word;
    logic [`HRS_IDX_W-1:0] tos_idx;

    // ------------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------------

    // entry index that a pointer value selects; the empty value maps to the top entry
    function automatic logic [`HRS_IDX_W-1:0] hrs_index(input hrs_ptr_t ptr);
        hrs_index = ptr[`HRS_IDX_W-1:0];
    endfunction : hrs_index

    // pointer value after one step, up or down, always five bits wide
    function automatic hrs_ptr_t hrs_step(input hrs_ptr_t ptr, input logic up);
        if (up) begin
            hrs_step = hrs_ptr_t'(ptr + 5'h01);
        end else begin
            hrs_step = hrs_ptr_t'(ptr - 5'h01);
        end
    endfunction : hrs_step

    // ------------------------------------------------------------------------
    // operation decode and fault detection
    // ------------------------------------------------------------------------

    // a push beside a pop cannot come from one instruction; the push is taken
    always_comb begin
        if (push) begin
            op = hrs_op_push; // R2
        end else if (pop) begin
            op = hrs_op_pop; // R3
        end else begin
            op = hrs_op_idle;
        end
        // the fifth pointer bit lets both faults be seen
        overflow = (op == hrs_op_push) && (stack_pointer == `HRS_PTR_TOP); // R8
        underflow = (op == hrs_op_pop) && (stack_pointer == `HRS_PTR_EMPTY); // R8
    end

    // ------------------------------------------------------------------------
    // top-of-stack view
    // ------------------------------------------------------------------------

    // the pointer names the entry in use, so the view is that entry
    always_comb begin
        tos_idx = hrs_index(stack_pointer); // R10
        tos_word = entries[tos_idx]; // R7
        if (stack_pointer == `HRS_PTR_EMPTY) begin
            if (stack_fault_reset_enable) begin
                tos_word = '0; // R12
            end else begin
                tos_word = entries[`HRS_IDX_TOP]; // R13
            end
        end
    end

    // ------------------------------------------------------------------------
    // entry write port
    // ------------------------------------------------------------------------

    // a push always beats a software write to the top pair in the same cycle
    always_comb begin
        mem_we = 1'b0;
        mem_idx = tos_idx;
        mem_wdata = entries[tos_idx];
        if (op == hrs_op_push) begin
            mem_we = 1'b1;
            // store lands at the incremented pointer; wrap reuses the oldest slot
            mem_idx = hrs_index(hrs_step(stack_pointer, 1'b1)); // R9 R5
            mem_wdata = push_pc; // R2
        end else if (reg_write && (reg_addr == `HRS_ADDR_TOS_LOW)) begin
            mem_we = 1'b1;
            mem_wdata = {entries[tos_idx][`HRS_PC_W-1:8], reg_wdata}; // R7
        end else if (reg_write && (reg_addr == `HRS_ADDR_TOS_HIGH)) begin
            mem_we = 1'b1;
            mem_wdata = {reg_wdata[`HRS_PC_W-9:0], entries[tos_idx][7:0]}; // R7
        end
    end

    // entries clear on reset so an empty stack never shows an undefined top entry
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            for (int i = 0; i < `HRS_DEPTH; i++) begin
                entries[i] <= '0;
            end
        end else if (mem_we) begin
            entries[mem_idx] <= mem_wdata; // R1
        end
    end

    // ------------------------------------------------------------------------
    // pointer, fault reset request and returned pc
    // ------------------------------------------------------------------------

    // the pc latch high register is not reached from here, so calls and returns
    // leave it as it stands
    always_comb begin
        next_stack_pointer = stack_pointer;
        next_ret_pc = ret_pc;
        next_stack_fault_reset = 1'b0;
        case (op)
            hrs_op_push: begin
                if (overflow && !stack_fault_reset_enable) begin
                    next_stack_pointer = '0; // R5
                end else begin
                    next_stack_pointer = hrs_step(stack_pointer, 1'b1); // R9 R4
                end
            end
            hrs_op_pop: begin
                // load first, from the entry in use, then step down
                next_ret_pc = tos_word; // R9 R3 R4
                if (underflow && !stack_fault_reset_enable) begin
                    next_stack_pointer = {1'b0, `HRS_IDX_TOP - 4'h1}; // R5
                end else begin
                    next_stack_pointer = hrs_step(stack_pointer, 1'b0); // R9
                end
            end
            default: begin
                // software may move the pointer only when the core leaves it alone
                if (reg_write && (reg_addr == `HRS_ADDR_PTR)) begin
                    next_stack_pointer = reg_wdata[`HRS_PTR_W-1:0]; // R7
                end
            end
        endcase
        // the device reset is asked for in addition to the flag
        if ((overflow || underflow) && stack_fault_reset_enable) begin
            next_stack_fault_reset = 1'b1; // R14
        end
    end

    // ------------------------------------------------------------------------
    // status, enable and interrupt
    // ------------------------------------------------------------------------

    // a fault in the cycle of its clear is kept: set wins over clear
    always_comb begin
        next_status = status;
        next_enable = enable;
        if (reg_write && (reg_addr == `HRS_ADDR_CLEAR)) begin
            next_status = status & ~reg_wdata[`HRS_EVT_W-1:0];
        end
        if (reg_write && (reg_addr == `HRS_ADDR_ENABLE)) begin
            next_enable = reg_wdata[`HRS_EVT_W-1:0];
        end
        next_status[`HRS_BIT_OVF] = next_status[`HRS_BIT_OVF] | overflow; // R6
        next_status[`HRS_BIT_UNF] = next_status[`HRS_BIT_UNF] | underflow; // R6
    end

    // level interrupt while any enabled flag stands
    assign irq = |(status & enable);

    // ------------------------------------------------------------------------
    // read port
    // ------------------------------------------------------------------------

    // read data is sampled at the strobe and stands only in the next cycle
    always_comb begin
        next_reg_rdata = 8'h00;
        if (reg_read) begin
            if (reg_addr == `HRS_ADDR_PTR) begin
                next_reg_rdata = {3'h0, stack_pointer}; // R7
            end else if (reg_addr == `HRS_ADDR_TOS_LOW) begin
                next_reg_rdata = tos_word[7:0]; // R7
            end else if (reg_addr == `HRS_ADDR_TOS_HIGH) begin
                next_reg_rdata = {1'b0, tos_word[`HRS_PC_W-1:8]}; // R7
            end else if (reg_addr == `HRS_ADDR_STATUS) begin
                next_reg_rdata = {6'h00, status};
            end else if (reg_addr == `HRS_ADDR_ENABLE) begin
                next_reg_rdata = {6'h00, enable};
            end else begin
                next_reg_rdata = 8'h00; // clear and unmapped offsets read zero
            end
        end
    end

    // ------------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------------

    // reset leaves the stack empty
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            stack_pointer <= `HRS_PTR_EMPTY; // R11
            status <= `HRS_EVT_RESET;
            enable <= `HRS_EVT_RESET;
            ret_pc <= '0;
            stack_fault_reset <= 1'b0;
            reg_rdata <= 8'h00;
        end else begin
            stack_pointer <= next_stack_pointer;
            status <= next_status;
            enable <= next_enable;
            ret_pc <= next_ret_pc;
            stack_fault_reset <= next_stack_fault_reset;
            reg_rdata <= next_reg_rdata;
        end
    end

    // ------------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);

    // a push that does not hit the top entry
    sequence s_plain_push;
        push && (stack_pointer != `HRS_PTR_TOP);
    endsequence

    // a pop from a stack that holds something
    sequence s_plain_pop;
        !push && pop && (stack_pointer != `HRS_PTR_EMPTY);
    endsequence

    // a seventeenth push with the fault reset off
    sequence s_wrap_push;
        push && (stack_pointer == `HRS_PTR_TOP) && !stack_fault_reset_enable;
    endsequence

    push_step_a: assert property (s_plain_push |=> // R9
        stack_pointer == hrs_ptr_t'($past(stack_pointer) + 5'h01))
        else $error("push did not advance the pointer by one");

    // a push that lands on the empty value with fault reset on reads as zero
    push_store_a: assert property (push && ((hrs_step(stack_pointer, 1'b1) != // R2
        `HRS_PTR_EMPTY) || !stack_fault_reset_enable) |=> tos_word == $past(push_pc))
        else $error("pushed pc is not on top of the stack");

    pop_return_a: assert property (s_plain_pop |=> // R3
        (ret_pc == $past(tos_word)) && (stack_pointer == hrs_ptr_t'($past(stack_pointer) - 5'h01)))
        else $error("pop did not return the top entry and step down");

    wrap_over_a: assert property (s_wrap_push |=> // R5
        (stack_pointer == 5'h00) && status[`HRS_BIT_OVF] && !stack_fault_reset)
        else $error("circular push did not wrap to the first entry");

    overflow_flag_a: assert property (push && (stack_pointer == `HRS_PTR_TOP) |=> // R6
        status[`HRS_BIT_OVF])
        else $error("overflow flag not set");

    underflow_flag_a: assert property (pop && !push && // R6
        (stack_pointer == `HRS_PTR_EMPTY) |=> status[`HRS_BIT_UNF])
        else $error("underflow flag not set");

    empty_zero_a: assert property ((stack_pointer == `HRS_PTR_EMPTY) && // R12
        stack_fault_reset_enable |-> tos_word == '0)
        else $error("empty stack top not zero with fault reset on");

    empty_top_a: assert property ((stack_pointer == `HRS_PTR_EMPTY) && // R13
        !stack_fault_reset_enable |-> tos_word == entries[`HRS_IDX_TOP])
        else $error("empty stack top not the highest entry");

    fault_reset_a: assert property ((overflow || underflow) && stack_fault_reset_enable // R14
        |=> stack_fault_reset ##1 !stack_fault_reset)
        else $error("fault reset request not a single pulse");

    pointer_write_a: assert property (reg_write && (reg_addr == `HRS_ADDR_PTR) && !push // R7
        && !pop |=> stack_pointer == $past(reg_wdata[`HRS_PTR_W-1:0]))
        else $error("software pointer write lost");

    status_hold_a: assert property (status[`HRS_BIT_OVF] && !(reg_write && // R6
        reg_addr == `HRS_ADDR_CLEAR && reg_wdata[`HRS_BIT_OVF]) |=> status[`HRS_BIT_OVF])
        else $error("overflow flag dropped without a clear");

endmodule : hrs_stack

// [tb/hrs_seq_model.sv]
// hrs_seq_model.sv - stand-in for the instruction sequencer and program counter
// assumes: the bench calls one task at a time; all changes land just after clk rises
`timescale 1ns/1ps

module hrs_seq_model
    import hrs_pkg::*;
(
    input wire logic clk,
    output logic push,
    output logic pop,
    output hrs_pc_t push_pc,
    input wire hrs_pc_t ret_pc
);
    // idle from time zero so the stack sees no stray operation
    initial begin
        push = 1'b0;
        pop = 1'b0;
        push_pc = 15'h0000;
    end

    // call, call via working reg or vectoring: pc held only for the push cycle
    task automatic do_push(input hrs_pc_t pc);
        @(posedge clk);
        push <= 1'b1;
        push_pc <= pc;
        @(posedge clk);
        push <= 1'b0;
        push_pc <= ~pc; // scrambled so a late sample of the pc shows up
    endtask : do_push

    // any return; loaded pc is taken once the pop edge has landed
    task automatic do_pop(output hrs_pc_t pc);
        @(posedge clk);
        pop <= 1'b1;
        @(posedge clk);
        pop <= 1'b0;
        #1 pc = ret_pc;
    endtask : do_pop
endmodule : hrs_seq_model

// [tb/testbench.sv]
// testbench.sv - self-checking bench for the hardware return stack
// assumes: hrs_seq_model plays the sequencer; registers driven over the plain port
`timescale 1ns/1ps

module testbench;
    import hrs_pkg::*;
    typedef struct {logic is_push; hrs_pc_t pc; hrs_ptr_t ptr; hrs_pc_t val;} hrs_row_t;
    logic clk, resetn, push, pop, fault_en, sfr, reg_write, reg_read, irq;
    hrs_pc_t push_pc, ret_pc, got;
    logic [3:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, b;
    int bad_count = 0;
    int comparisons = 0;
    int pulses = 0;
    int p0;
    // push/pop sequence with pointer and value each step should leave
    hrs_row_t rows [8] = '{'{1'b1, 15'h1234, 5'h00, 15'h1234},
        '{1'b1, 15'h7FFF, 5'h01, 15'h7FFF}, '{1'b1, 15'h0001, 5'h02, 15'h0001},
        '{1'b0, 15'h0000, 5'h01, 15'h0001}, '{1'b0, 15'h0000, 5'h00, 15'h7FFF},
        '{1'b1, 15'h5555, 5'h01, 15'h5555}, '{1'b0, 15'h0000, 5'h00, 15'h5555},
        '{1'b0, 15'h0000, 5'h1F, 15'h1234}};

    hrs_seq_model u_hrs_seq_model (.clk(clk), .push(push), .pop(pop), .push_pc(push_pc),
        .ret_pc(ret_pc));
    hrs_stack u_hrs_stack (.clk(clk), .resetn(resetn), .push(push), .pop(pop),
        .push_pc(push_pc), .ret_pc(ret_pc), .stack_fault_reset_enable(fault_en),
        .stack_fault_reset(sfr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .irq(irq));

    // ------------------------------------------------------------------
    // bus and check tasks
    // ------------------------------------------------------------------
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // write lands at the strobe edge; #1 lets its effect settle
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_write <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_write <= 1'b0;
        #1;
    endtask : wr

    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [3:0] a);
        @(posedge clk);
        reg_read <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_read <= 1'b0;
        #1 b = reg_rdata;
    endtask : rd

    task automatic rd_tos();
        logic [7:0] lo;
        rd(4'h1);
        lo = b;
        rd(4'h2);
        got = {b[6:0], lo};
    endtask : rd_tos

    task automatic do_reset();
        resetn <= 1'b0;
        repeat (10) @(posedge clk);
        resetn <= 1'b1;
    endtask : do_reset

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : report_and_stop

    // ------------------------------------------------------------------
    // clock, fault pulse counter, watchdog
    // ------------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // counting pulses rather than sampling once tolerates either pulse cycle
    always @(posedge clk) begin
        if (sfr === 1'b1) pulses++;
    end

    initial begin
        #50000;
        bad_count++;
        report_and_stop();
    end

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        resetn = 1'b0;
        fault_en = 1'b1;
        reg_write = 1'b0;
        reg_read = 1'b0;
        reg_addr = 4'h0;
        reg_wdata = 8'h00;
        do_reset();
        rd(4'h0);
        chk(b, 16'h001F);
        rd(4'h3);
        chk(b, 16'h0000);
        $display("test reset done");
        foreach (rows[i]) begin
            if (rows[i].is_push) begin
                u_hrs_seq_model.do_push(rows[i].pc);
                rd_tos();
            end else begin
                u_hrs_seq_model.do_pop(got);
            end
            chk(got, rows[i].val);
            rd(4'h0);
            chk(b, rows[i].ptr);
        end
        $display("test push pop rows done");
        rd_tos();
        chk(got, 16'h0000);
        p0 = pulses;
        u_hrs_seq_model.do_pop(got);
        repeat (3) @(posedge clk);
        #1 chk(16'(pulses - p0), 16'h0001);
        chk(got, 16'h0000);
        rd(4'h0);
        chk(b, 16'h001E);
        rd(4'h3);
        chk(b, 16'h0002);
        chk(irq, 1'b0);
        wr(4'h5, 8'h02);
        chk(irq, 1'b1);
        rd(4'h5);
        chk(b, 16'h0002);
        wr(4'h4, 8'h02);
        chk(irq, 1'b0);
        $display("test underflow with fault reset done");
        fault_en <= 1'b0;
        do_reset();
        p0 = pulses;
        for (int i = 0; i < 17; i++) u_hrs_seq_model.do_push(15'h0100 + 15'(i));
        rd(4'h0);
        chk(b, 16'h0000);
        rd_tos();
        chk(got, 16'h0110);
        rd(4'h3);
        chk(b, 16'h0001);
        u_hrs_seq_model.do_pop(got);
        chk(got, 16'h0110);
        rd_tos();
        chk(got, 16'h010F);
        u_hrs_seq_model.do_pop(got);
        chk(got, 16'h010F);
        rd(4'h0);
        chk(b, 16'h000E);
        chk(16'(pulses - p0), 16'h0000);
        $display("test circular mode done");
        wr(4'h0, 8'h03);
        rd_tos();
        chk(got, 16'h0103);
        wr(4'h1, 8'hAB);
        wr(4'h2, 8'h12);
        rd_tos();
        chk(got, 16'h12AB);
        wr(4'h3, 8'h00);
        rd(4'h3);
        chk(b, 16'h0003);
        rd(4'h9);
        chk(b, 16'h0000);
        $display("test software access done");
        report_and_stop();
    end
endmodule : testbench
